// file: logic/aeb_sequencer.sv
// slot sequencer with burst triggering and four conversion interrupts
//
// Summary of operation
// RL1: burst mode ignores round-robin slots' own triggers
// RL2: one burst trigger source serves all round-robin slots
// RL3: burst marks count plus one slots pending
// RL4: software lets each burst finish first
// RL5: software keeps burst size within round-robin group
// RL6: pointer holds last burst slot; bursts rotate
// RL7: high-priority slot converts first, pointer unchanged
// RL8: per-slot end pulse, position selectable
// RL9: four lines, each sourced from any slot
// RL10: flags readable and forwarded to expansion unit
// RL11: busy clear means ready, not sequence done
// RL12: event on set flag raises overflow
// RL13: overflow event not forwarded unless continue mode; overflow never blocks
// RL14: continue mode forwards every event
// RL15: overflow set regardless of continue mode
// RL16: write one clears flag or overflow
// RL17: early timing needs end-of-acquisition position
// RL18: early flag delay after acquisition falls
// RL19: delay past conversion end fires at end
// RL20: end-of-conversion position ignores the delay
// RL21: pointer wraps; reset value gives slot zero priority
// RL22: slots below boundary high priority, lowest wins
// RL23: high priority waits for current conversion
// RL24: burst trigger ignored when burst disabled
`timescale 1ns/1ps
module aeb_sequencer (
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    input  wire logic [15:0] trig_i,
    input  wire logic [5:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    output logic             soc_o,
    output logic      [3:0]  slot_o,
    output logic      [15:0] eoc_o,
    output logic             busy_o,
    output logic      [3:0]  int_o
);

    aeb_pkg::aeb_top_state_t s;
    aeb_pkg::aeb_top_state_t next_s;

    logic [aeb_pkg::NLINE-1:0] line_evt;
    logic [aeb_pkg::NLINE-1:0] flag_clr;
    logic [aeb_pkg::NLINE-1:0] ovf_clr;
    logic [aeb_pkg::NLINE-1:0] flags;
    logic [aeb_pkg::NLINE-1:0] ovfs;
    logic [aeb_pkg::NSLOT-1:0] burst_set;
    logic [aeb_pkg::NSLOT-1:0] own_set;
    logic [3:0]                hp_slot;
    logic [3:0]                rr_slot;
    logic [4:0]                rr_start;
    logic [4:0]                burst_start;
    logic                      hp_found;
    logic                      rr_found;
    logic                      btrig_hit;
    logic                      int_now;

    assign flag_clr = (wr_i && addr_i == aeb_pkg::ADDR_FLAG_CLR) ?
                      wdata_i[3:0] : 4'h0;
    assign ovf_clr  = (wr_i && addr_i == aeb_pkg::ADDR_OVF_CLR) ?
                      wdata_i[3:0] : 4'h0;

    // next slot after the pointer, wrapping past the top slot
    assign rr_start = (s.rr >= aeb_pkg::SLOT_LAST) ? 5'h00 : s.rr + 5'h01; // [RL21]
    assign burst_start = (rr_start < s.cfg.bnd) ? s.cfg.bnd : rr_start;
    assign btrig_hit = s.cfg.burst_en & trig_i[s.cfg.btrig]; // [RL2] [RL24]

    // trigger decoding and burst window
    always_comb begin
        logic [4:0] d;
        logic [4:0] group;
        d = 5'h00;
        group = aeb_pkg::SLOT_ALL - s.cfg.bnd;
        burst_set = '0;
        own_set = '0;
        for (int j = 0; j < aeb_pkg::NSLOT; j++) begin
            if (5'(j) >= burst_start) begin
                d = 5'(j) - burst_start;
            end else begin
                d = 5'(j) + group - burst_start;
            end
            // consecutive slots from the wheel head, count plus one
            burst_set[j] = btrig_hit && 5'(j) >= s.cfg.bnd &&
                           d <= {1'b0, s.cfg.bcnt}; // [RL3] [RL6]
            // own trigger stays live for high-priority slots
            own_set[j] = trig_i[s.tsel[j]] &&
                         !(s.cfg.burst_en && 5'(j) >= s.cfg.bnd); // [RL1]
        end
    end

    // arbitration: lowest high-priority slot, else the wheel
    always_comb begin
        logic [3:0] idx;
        idx = 4'h0;
        hp_found = 1'b0;
        hp_slot = 4'h0;
        rr_found = 1'b0;
        rr_slot = 4'h0;
        for (int j = aeb_pkg::NSLOT - 1; j >= 0; j--) begin
            if (s.pend[j] && 5'(j) < s.cfg.bnd) begin
                hp_found = 1'b1;
                hp_slot = 4'(j); // [RL22]
            end
        end
        for (int k = 0; k < aeb_pkg::NSLOT; k++) begin
            idx = 4'(rr_start[3:0] + 4'(k));
            if (!rr_found && s.pend[idx] && {1'b0, idx} >= s.cfg.bnd) begin
                rr_found = 1'b1;
                rr_slot = idx; // [RL21]
            end
        end
    end

    always_comb begin
        logic [3:0] pick;
        logic [3:0] ti;
        pick = hp_found ? hp_slot : rr_slot; // [RL7] [RL23]
        ti = 4'(addr_i - aeb_pkg::ADDR_TSEL_BASE);
        next_s = s;
        int_now = 1'b0;
        next_s.eoc = '0;
        next_s.rdata = 32'h0000_0000;
        next_s.pend = s.pend & ~((s.phase == aeb_pkg::ST_IDLE &&
                      (hp_found || rr_found)) ? (16'h0001 << pick) : 16'h0000);
        unique case (s.phase)
            aeb_pkg::ST_IDLE: begin
                // a pending trigger only starts once the converter is free
                if (hp_found || rr_found) begin
                    next_s.phase = aeb_pkg::ST_ACQ;
                    next_s.slot = pick;
                    next_s.cnt = 8'(aeb_pkg::ACQ_CYC - 1);
                    next_s.soc = 1'b1;
                    next_s.busy = 1'b1;
                end
            end
            aeb_pkg::ST_ACQ: begin
                if (s.cnt == 8'h00) begin
                    next_s.phase = aeb_pkg::ST_CONV;
                    next_s.soc = 1'b0;
                    next_s.cnt = 8'(aeb_pkg::CONV_CYC - 1);
                    next_s.ecnt = 8'h01;
                    next_s.eoc[s.slot] = ~s.cfg.pos; // [RL8]
                    int_now = ~s.cfg.pos && s.early == 8'h00; // [RL18]
                    next_s.fired = int_now;
                end else begin
                    next_s.cnt = s.cnt - 8'h01;
                end
            end
            aeb_pkg::ST_CONV: begin
                if (s.cnt == 8'h00) begin
                    next_s.phase = aeb_pkg::ST_IDLE;
                    // busy drops as soon as a new slot may start
                    next_s.busy = 1'b0; // [RL11]
                    next_s.eoc[s.slot] = s.cfg.pos; // [RL8]
                    int_now = s.cfg.pos || !s.fired; // [RL19] [RL20]
                    if ({1'b0, s.slot} >= s.cfg.bnd) begin
                        next_s.rr = {1'b0, s.slot}; // [RL6] [RL7]
                    end
                end else begin
                    next_s.cnt = s.cnt - 8'h01;
                    next_s.ecnt = s.ecnt + 8'h01;
                    if (!s.cfg.pos && !s.fired && s.ecnt == s.early) begin
                        int_now = 1'b1; // [RL18] [RL17]
                        next_s.fired = 1'b1;
                    end
                end
            end
            default: begin
                next_s.phase = aeb_pkg::ST_IDLE;
            end
        endcase
        // new triggers beat the clear of a starting slot
        next_s.pend = next_s.pend | burst_set | own_set;
        if (wr_i) begin
            unique case (addr_i)
                aeb_pkg::ADDR_CTRL: begin
                    next_s.cfg.burst_en = wdata_i[aeb_pkg::CTRL_BURST_EN];
                    next_s.cfg.btrig = wdata_i[aeb_pkg::CTRL_BTRIG +: 4];
                    next_s.cfg.bcnt = wdata_i[aeb_pkg::CTRL_BCNT +: 4];
                    next_s.cfg.bnd = wdata_i[aeb_pkg::CTRL_BND +: 5];
                    next_s.cfg.pos = wdata_i[aeb_pkg::CTRL_POS];
                end
                aeb_pkg::ADDR_INTSEL: begin
                    for (int l = 0; l < aeb_pkg::NLINE; l++) begin
                        next_s.lcfg[l].src =
                            wdata_i[l * aeb_pkg::ISEL_STRIDE +: 4]; // [RL9]
                        next_s.lcfg[l].cont = wdata_i[l * aeb_pkg::ISEL_STRIDE
                                              + aeb_pkg::ISEL_CONT];
                    end
                end
                aeb_pkg::ADDR_EARLY: next_s.early = wdata_i[7:0];
                aeb_pkg::ADDR_PEND: next_s.pend = next_s.pend | wdata_i[15:0];
                default: begin
                    if (addr_i >= aeb_pkg::ADDR_TSEL_BASE) begin
                        next_s.tsel[ti] = wdata_i[3:0];
                    end
                end
            endcase
        end
        if (rd_i) begin
            unique case (addr_i)
                aeb_pkg::ADDR_CTRL: begin
                    next_s.rdata[aeb_pkg::CTRL_BURST_EN] = s.cfg.burst_en;
                    next_s.rdata[aeb_pkg::CTRL_BTRIG +: 4] = s.cfg.btrig;
                    next_s.rdata[aeb_pkg::CTRL_BCNT +: 4] = s.cfg.bcnt;
                    next_s.rdata[aeb_pkg::CTRL_BND +: 5] = s.cfg.bnd;
                    next_s.rdata[aeb_pkg::CTRL_POS] = s.cfg.pos;
                end
                aeb_pkg::ADDR_INTSEL: begin
                    for (int l = 0; l < aeb_pkg::NLINE; l++) begin
                        next_s.rdata[l * aeb_pkg::ISEL_STRIDE +: 5] = s.lcfg[l];
                    end
                end
                aeb_pkg::ADDR_EARLY: next_s.rdata[7:0] = s.early;
                aeb_pkg::ADDR_STAT: begin
                    next_s.rdata[aeb_pkg::STAT_FLAG +: 4] = flags; // [RL10]
                    next_s.rdata[aeb_pkg::STAT_OVF +: 4] = ovfs;
                    next_s.rdata[aeb_pkg::STAT_RR +: 5] = s.rr;
                    next_s.rdata[aeb_pkg::STAT_BUSY] = s.busy;
                end
                aeb_pkg::ADDR_PEND: next_s.rdata[15:0] = s.pend;
                default: begin
                    if (addr_i >= aeb_pkg::ADDR_TSEL_BASE) begin
                        next_s.rdata[3:0] = s.tsel[ti];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            s <= '0;
            s.phase <= aeb_pkg::ST_IDLE;
            s.rr <= aeb_pkg::RR_RESET; // [RL21]
            s.cfg.bnd <= aeb_pkg::BND_RESET;
        end else begin
            s <= next_s;
        end
    end

    genvar g;
    generate
        for (g = 0; g < aeb_pkg::NLINE; g++) begin : g_line
            assign line_evt[g] = int_now && s.slot == s.lcfg[g].src; // [RL9]
            aeb_int_line u_line (
                .ref_clk_i  (ref_clk_i),
                .rstn_i     (rstn_i),
                .evt_i      (line_evt[g]),
                .cont_i     (s.lcfg[g].cont),
                .flag_clr_i (flag_clr[g]),
                .ovf_clr_i  (ovf_clr[g]),
                .flag_o     (flags[g]),
                .ovf_o      (ovfs[g]),
                .fwd_o      (int_o[g])
            );
        end
    endgenerate

    assign rdata_o = s.rdata;
    assign soc_o   = s.soc;
    assign slot_o  = s.slot;
    assign eoc_o   = s.eoc;
    assign busy_o  = s.busy;

    AST_BURST_SIZE: assert property (@(posedge ref_clk_i) // [RL3]
        disable iff (!rstn_i)
        (btrig_hit && {1'b0, s.cfg.bcnt} < aeb_pkg::SLOT_ALL - s.cfg.bnd)
        |-> $countones(burst_set) == int'(s.cfg.bcnt) + 1)
        else $error("burst marked wrong number of slots");
    AST_BURST_OFF: assert property (@(posedge ref_clk_i) // [RL24]
        disable iff (!rstn_i) !s.cfg.burst_en |-> burst_set == '0)
        else $error("burst trigger acted while burst disabled");
    AST_HP_FIRST: assert property (@(posedge ref_clk_i) // [RL7]
        disable iff (!rstn_i) (s.phase == aeb_pkg::ST_IDLE && hp_found)
        |=> s.soc && s.slot == $past(hp_slot))
        else $error("high-priority slot not converted first");
    AST_RR_KEEP: assert property (@(posedge ref_clk_i) // [RL7]
        disable iff (!rstn_i) (s.phase == aeb_pkg::ST_CONV && s.cnt == 8'h00
        && {1'b0, s.slot} < s.cfg.bnd) |=> $stable(s.rr))
        else $error("pointer moved on high-priority conversion");
    AST_RR_MOVE: assert property (@(posedge ref_clk_i) // [RL6]
        disable iff (!rstn_i) (s.phase == aeb_pkg::ST_CONV && s.cnt == 8'h00
        && {1'b0, s.slot} >= s.cfg.bnd) |=> s.rr == {1'b0, $past(s.slot)})
        else $error("pointer not left on last converted slot");
    AST_EOC_END: assert property (@(posedge ref_clk_i) // [RL8]
        disable iff (!rstn_i) (s.phase == aeb_pkg::ST_CONV && s.cnt == 8'h00
        && s.cfg.pos) |=> eoc_o == (16'h0001 << $past(s.slot)) && !busy_o)
        else $error("end pulse missing at conversion end");
    AST_EARLY_TIME: assert property (@(posedge ref_clk_i) // [RL18]
        disable iff (!rstn_i) (int_now && !s.cfg.pos) |->
        (s.phase == aeb_pkg::ST_ACQ && s.early == 8'h00) ||
        (s.phase == aeb_pkg::ST_CONV && (s.ecnt == s.early || s.cnt == 8'h00)))
        else $error("early interrupt at wrong time");
    AST_ONE_PER_SLOT: assert property (@(posedge ref_clk_i) // [RL19]
        disable iff (!rstn_i) (int_now && s.phase == aeb_pkg::ST_CONV)
        |=> !int_now)
        else $error("two interrupt events for one slot");
    COV_BURST: cover property (@(posedge ref_clk_i)
        disable iff (!rstn_i) btrig_hit ##1 s.soc);
    COV_HP_IN_BURST: cover property (@(posedge ref_clk_i)
        disable iff (!rstn_i) btrig_hit && own_set != '0 && s.cfg.bnd != 0);
    COV_EARLY: cover property (@(posedge ref_clk_i)
        disable iff (!rstn_i) int_now && s.phase == aeb_pkg::ST_CONV
        && s.cnt != 8'h00);

endmodule : aeb_sequencer

// file: logic/aeb_pkg.sv
// shared constants and types of the burst sequencer and interrupt lines
package aeb_pkg;

    localparam int NSLOT = 16;
    localparam int NLINE = 4;
    localparam int NTRIG = 16;

    // word addresses on the plain register port
    localparam logic [5:0] ADDR_CTRL      = 6'h00;
    localparam logic [5:0] ADDR_INTSEL    = 6'h01;
    localparam logic [5:0] ADDR_EARLY     = 6'h02;
    localparam logic [5:0] ADDR_STAT      = 6'h03;
    localparam logic [5:0] ADDR_FLAG_CLR  = 6'h04;
    localparam logic [5:0] ADDR_OVF_CLR   = 6'h05;
    localparam logic [5:0] ADDR_PEND      = 6'h06;
    localparam logic [5:0] ADDR_TSEL_BASE = 6'h10;

    // field positions of the control word
    localparam int CTRL_BURST_EN = 0;
    localparam int CTRL_BTRIG    = 4;
    localparam int CTRL_BCNT     = 8;
    localparam int CTRL_BND      = 12;
    localparam int CTRL_POS      = 20;
    // field positions of the status word
    localparam int STAT_FLAG     = 0;
    localparam int STAT_OVF      = 4;
    localparam int STAT_RR       = 8;
    localparam int STAT_BUSY     = 16;
    // per line byte in the interrupt select word
    localparam int ISEL_STRIDE   = 8;
    localparam int ISEL_CONT     = 4;

    // reset values and slot range limits
    localparam logic [4:0] RR_RESET  = 5'h10;
    localparam logic [4:0] BND_RESET = 5'h00;
    localparam logic [4:0] SLOT_ALL  = 5'h10;
    localparam logic [4:0] SLOT_LAST = 5'h0f;

    // converter timing, rounded up to whole cycles
    localparam int CLK_NS  = 10;
    localparam int ACQ_NS  = 100;
    localparam int CONV_NS = 110;
    localparam int ACQ_CYC  = (ACQ_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV} aeb_phase_t;

    typedef struct packed {
        logic       burst_en;
        logic [3:0] btrig;
        logic [3:0] bcnt;
        logic [4:0] bnd;
        logic       pos;
    } aeb_cfg_t;

    typedef struct packed {
        logic [3:0] src;
        logic       cont;
    } aeb_line_cfg_t;

    typedef struct packed {
        logic flag;
        logic ovf;
        logic fwd;
    } aeb_line_state_t;

    typedef struct packed {
        aeb_phase_t                phase;
        logic [3:0]                slot;
        logic [7:0]                cnt;
        logic [7:0]                ecnt;
        logic                      fired;
        logic [4:0]                rr;
        logic [NSLOT-1:0]          pend;
        aeb_cfg_t                  cfg;
        aeb_line_cfg_t [NLINE-1:0] lcfg;
        logic [7:0]                early;
        logic [NSLOT-1:0][3:0]     tsel;
        logic [NSLOT-1:0]          eoc;
        logic                      soc;
        logic                      busy;
        logic [31:0]               rdata;
    } aeb_top_state_t;

endpackage : aeb_pkg

// file: logic/aeb_int_line.sv
// one conversion interrupt line: flag, overflow and forwarding
`timescale 1ns/1ps
module aeb_int_line (
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    input  wire logic evt_i,
    input  wire logic cont_i,
    input  wire logic flag_clr_i,
    input  wire logic ovf_clr_i,
    output logic      flag_o,
    output logic      ovf_o,
    output logic      fwd_o
);

    aeb_pkg::aeb_line_state_t s;
    aeb_pkg::aeb_line_state_t next_s;

    always_comb begin
        next_s = s;
        // a new event beats a clear in the same cycle
        next_s.flag = evt_i | (s.flag & ~flag_clr_i); // [RL10] [RL16]
        next_s.ovf  = (evt_i & s.flag) | (s.ovf & ~ovf_clr_i); // [RL12] [RL15]
        // overflow bit itself never gates forwarding
        next_s.fwd  = evt_i & (~s.flag | cont_i); // [RL13] [RL14]
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign flag_o = s.flag;
    assign ovf_o  = s.ovf;
    assign fwd_o  = s.fwd;

    AST_OVF_ON_SET_FLAG: assert property (@(posedge ref_clk_i) // [RL15]
        disable iff (!rstn_i) (evt_i && flag_o) |=> ovf_o)
        else $error("event on set flag did not raise overflow");
    AST_NO_FWD_OVERLAP: assert property (@(posedge ref_clk_i) // [RL13]
        disable iff (!rstn_i) (evt_i && flag_o && !cont_i) |=> !fwd_o)
        else $error("overlapping event forwarded without continue mode");
    AST_FWD_CONTINUE: assert property (@(posedge ref_clk_i) // [RL14]
        disable iff (!rstn_i) (evt_i && (cont_i || !flag_o)) |=> fwd_o)
        else $error("event not forwarded");
    AST_SET_BEATS_CLEAR: assert property (@(posedge ref_clk_i) // [RL16]
        disable iff (!rstn_i) (evt_i && flag_clr_i) |=> flag_o)
        else $error("clear beat a coincident event");
    AST_CLEAR_WORKS: assert property (@(posedge ref_clk_i) // [RL16]
        disable iff (!rstn_i) (!evt_i && flag_clr_i) |=> !flag_o)
        else $error("flag clear had no effect");
    COV_OVERFLOW: cover property (@(posedge ref_clk_i)
        disable iff (!rstn_i) $rose(ovf_o));

endmodule : aeb_int_line

// file: test/aeb_far_model.sv
// trigger sources and interrupt expansion unit standing at the far side
`timescale 1ns/1ps
module aeb_far_model (
    input  wire logic            ref_clk_i,
    input  wire logic            rstn_i,
    input  wire logic [15:0]     fire_i,
    input  wire logic [3:0]      int_i,
    output logic      [15:0]     trig_o,
    output logic      [3:0][7:0] int_cnt_o
);
    // trigger lines are one-cycle pulses and low between them
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            trig_o    <= 16'h0000;
            int_cnt_o <= 32'h00000000;
        end else begin
            trig_o <= fire_i;
            for (int l = 0; l < 4; l++) begin
                if (int_i[l]) begin
                    int_cnt_o[l] <= int_cnt_o[l] + 8'h01;
                end
            end
        end
    end
endmodule : aeb_far_model

// file: test/adc_burst_and_eoc_interrupts_tb.sv
// self-checking bench of the burst sequencer and interrupt lines
`timescale 1ns/1ps
module adc_burst_and_eoc_interrupts_tb;
    logic            ref_clk_i, rstn_i, wr_i, rd_i, soc_o, busy_o, pos;
    logic [5:0]      addr_i;
    logic [31:0]     wdata_i, rdata_o;
    logic [15:0]     trig_i, fire, eoc_o;
    logic [3:0]      slot_o, int_o;
    logic [3:0][7:0] int_cnt;
    logic [7:0]      d;
    logic [4:0]      rr;
    logic [3:0]      bc;
    int              failures, n_tests, de, di;
    int              q[$];

    aeb_sequencer i_aeb_sequencer (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .trig_i(trig_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .soc_o(soc_o), .slot_o(slot_o),
        .eoc_o(eoc_o), .busy_o(busy_o), .int_o(int_o));
    aeb_far_model i_aeb_far_model (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .fire_i(fire), .int_i(int_o), .trig_o(trig_i), .int_cnt_o(int_cnt));

    function automatic logic [31:0] ctrl(logic en, logic [3:0] bt,
                                         logic [3:0] bn, logic [4:0] bd,
                                         logic p);
        return {11'h000, p, 3'h0, bd, bn, bt, 3'h0, en};
    endfunction : ctrl
    // next round-robin slot after the pointer, wrapping to the boundary
    function automatic logic [4:0] nxt(logic [4:0] r, logic [4:0] b);
        return (r >= 5'h0f || r < b) ? b : r + 5'h01;
    endfunction : nxt
    // late delays fall back to the conversion end, 11 cycles later
    function automatic int exp_int(logic p, logic [7:0] dd);
        return (p || dd >= 8'h0b) ? 11 : int'(dd);
    endfunction : exp_int

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        @(posedge ref_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= v;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
        @(posedge ref_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask : rdchk
    task automatic fire_trig(input logic [15:0] m);
        @(posedge ref_clk_i);
        fire <= m;
        @(posedge ref_clk_i);
        fire <= 16'h0000;
    endtask : fire_trig
    task automatic step();
        @(posedge ref_clk_i);
        #1;
    endtask : step
    task automatic collect(input int cyc);
        q.delete();
        repeat (cyc) begin
            step();
            for (int j = 0; j < 16; j++) begin
                if (eoc_o[j] === 1'b1) begin
                    q.push_back(j);
                    check(slot_o, j);
                    check(busy_o, 1'b0);
                end
            end
        end
    endtask : collect
    // offsets of end pulse and line 0 interrupt from the acquisition fall
    task automatic lat();
        int k;
        k  = 0;
        de = -1;
        di = -1;
        while (soc_o !== 1'b1 && k < 60) begin
            step();
            k++;
        end
        while (soc_o !== 1'b0 && k < 60) begin
            step();
            k++;
        end
        for (int c = 0; c < 20; c++) begin
            if (eoc_o[0] === 1'b1 && de < 0) de = c;
            if (int_o[0] === 1'b1 && di < 0) di = c;
            step();
        end
    endtask : lat
    task automatic final_report();
        $display("compares %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // whole run needs about 1300 cycles
    initial begin
        #200000;
        failures++;
        final_report();
    end

    initial begin
        rstn_i   = 1'b0;
        wr_i     = 1'b0;
        rd_i     = 1'b0;
        addr_i   = 6'h00;
        wdata_i  = 32'h00000000;
        fire     = 16'h0000;
        failures = 0;
        n_tests  = 0;
        void'($urandom(45));
        repeat (5) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        rdchk(aeb_pkg::ADDR_STAT, 32'h00001000);
        rdchk(6'h3f, 32'h00000000);
        // every slot selects trigger 0 after reset; park the others on 15
        for (int j = 1; j < 16; j++) begin
            wr(aeb_pkg::ADDR_TSEL_BASE + 6'(j), 32'h0000000f);
        end
        rdchk(aeb_pkg::ADDR_TSEL_BASE + 6'h01, 32'h0000000f);
        $display("test 1 reset values done");
        // all lines watch slot 0, only line 3 in continue mode
        wr(aeb_pkg::ADDR_INTSEL, 32'h10000000);
        fire_trig(16'h0001);
        lat();
        check(di, 0);
        rdchk(aeb_pkg::ADDR_STAT, 32'h0000000f);
        check(int_cnt, 32'h01010101);
        fire_trig(16'h0001);
        lat();
        rdchk(aeb_pkg::ADDR_STAT, 32'h000000ff);
        check(int_cnt, 32'h02010101);
        wr(aeb_pkg::ADDR_FLAG_CLR, 32'h00000005);
        wr(aeb_pkg::ADDR_OVF_CLR, 32'h00000003);
        rdchk(aeb_pkg::ADDR_STAT, 32'h000000ca);
        fire_trig(16'h0001);
        lat();
        rdchk(aeb_pkg::ADDR_STAT, 32'h000000ef);
        check(int_cnt, 32'h03020102);
        wr(aeb_pkg::ADDR_FLAG_CLR, 32'h0000000f);
        wr(aeb_pkg::ADDR_OVF_CLR, 32'h0000000f);
        $display("test 2 flags and overflow done");
        for (int i = 0; i < 8; i++) begin
            d   = (i == 0) ? 8'h0b : (i == 1) ? 8'h0a : 8'($urandom_range(0, 20));
            pos = (i >= 5);
            wr(aeb_pkg::ADDR_CTRL, ctrl(1'b0, 4'h0, 4'h0, 5'h00, pos));
            wr(aeb_pkg::ADDR_EARLY, {24'h000000, d});
            fire_trig(16'h0001);
            lat();
            check(de, pos ? 11 : 0);
            check(di, exp_int(pos, d));
            wr(aeb_pkg::ADDR_FLAG_CLR, 32'h0000000f);
        end
        $display("test 3 early interrupt timing done");
        rr = 5'h00;
        for (int b = 0; b < 5; b++) begin
            bc = 4'($urandom_range(0, 3));
            wr(aeb_pkg::ADDR_CTRL, ctrl(1'b1, 4'h5, bc, 5'h04, 1'b1));
            fire_trig(16'h0020);
            collect(25 * int'(bc) + 50);
            check(q.size(), int'(bc) + 1);
            for (int k = 0; k <= int'(bc); k++) begin
                rr = nxt(rr, 5'h04);
                check(q[k], rr);
            end
            rdchk(aeb_pkg::ADDR_STAT, {19'h00000, rr, 8'h00});
        end
        // slots 0 to 3 share trigger 0 so they race for high priority
        for (int j = 1; j < 4; j++) begin
            wr(aeb_pkg::ADDR_TSEL_BASE + 6'(j), 32'h00000000);
        end
        wr(aeb_pkg::ADDR_CTRL, ctrl(1'b1, 4'h5, 4'h1, 5'h04, 1'b1));
        fire_trig(16'h0021);
        collect(200);
        check(q.size(), 6);
        for (int k = 0; k < 4; k++) begin
            check(q[k], k);
        end
        check(q[4], nxt(rr, 5'h04));
        check(q[5], nxt(nxt(rr, 5'h04), 5'h04));
        wr(aeb_pkg::ADDR_FLAG_CLR, 32'h0000000f);
        rdchk(aeb_pkg::ADDR_STAT, {19'h00000, 5'(q[5]), 8'h00});
        $display("test 4 burst rotation and priority done");
        wr(aeb_pkg::ADDR_CTRL, ctrl(1'b0, 4'h5, 4'h1, 5'h04, 1'b1));
        fire_trig(16'h0020);
        collect(60);
        check(q.size(), 0);
        rdchk(aeb_pkg::ADDR_PEND, 32'h00000000);
        wr(aeb_pkg::ADDR_PEND, 32'h00000002);
        collect(40);
        check(q.size(), 1);
        check((q.size() > 0) ? q[0] : -1, 1);
        $display("test 5 burst disabled done");
        final_report();
    end
endmodule : adc_burst_and_eoc_interrupts_tb
